/* File: core/dio_test_top.sv */
// Discrete I/O test-mode logic with an APB register slave.
module dio_test_top #(
	parameter int unsigned NCH = dio_pkg::DIO_NCH,
	parameter int unsigned CNT_W = dio_pkg::DIO_CNT_W,
	parameter logic [CNT_W-1:0] WIDTH_RST = CNT_W'(dio_pkg::DIO_PULSE_CYC_DEF),
	parameter logic [CNT_W-1:0] HOLD_RST = CNT_W'(dio_pkg::DIO_HOLD_CYC_DEF)
) (
	// Clock, reset and enable
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	// APB slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic o_pready,
	output logic o_pslverr,
	output logic [31:0] o_prdata,
	// Discrete inputs
	input wire logic [NCH-1:0] i_loop_in,
	input wire logic [NCH-1:0] i_gate_in,
	// Normal read indications per channel
	input wire logic [NCH-1:0] i_read_light,
	// Discrete outputs
	output logic [NCH-1:0] o_lamp_out,
	output logic [NCH-1:0] o_gate_out,
	// Channel lights, bit 0 is channel A
	output logic o_channel_a_light,
	output logic o_channel_b_light,
	output logic o_channel_c_light,
	output logic o_channel_d_light,
	// Normal reading allowed
	output logic o_normal_en
);

	// ----------------------------------------
	// Register state
	// ----------------------------------------
	typedef struct packed {
		logic test_en;
		dio_pkg::dio_opt_t opt;
		logic [15:0] pol;
		logic [CNT_W-1:0] width;
		logic [CNT_W-1:0] hold;
		logic [NCH-1:0] trig;
		logic [31:0] prdata;
		logic pslverr;
		logic [NCH-1:0] lamp;
		logic [NCH-1:0] gate;
		logic [NCH-1:0] lights;
		logic normal_en;
	} dio_reg_t;

	dio_reg_t r_q;
	dio_reg_t r_d;

	logic [NCH-1:0] ch_active;
	logic [NCH-1:0] ch_holding;
	logic [NCH-1:0] in_asserted;

	// Decode a byte address into a known register.
	function automatic logic dio_is_mapped(input logic [11:0] a);
		dio_is_mapped = (a == dio_pkg::DIO_A_CTRL) || (a == dio_pkg::DIO_A_POL) ||
			(a == dio_pkg::DIO_A_WIDTH) || (a == dio_pkg::DIO_A_HOLD) ||
			(a == dio_pkg::DIO_A_TRIG) || (a == dio_pkg::DIO_A_STAT);
	endfunction : dio_is_mapped

	// Only options one to four are accepted; others map to none.
	function automatic dio_pkg::dio_opt_t dio_opt_dec(input logic [2:0] v);
		case (v)
			3'h1: dio_opt_dec = dio_pkg::DIO_OPT_ECHO_LOOP;
			3'h2: dio_opt_dec = dio_pkg::DIO_OPT_ECHO_GATE;
			3'h3: dio_opt_dec = dio_pkg::DIO_OPT_TRIG_LAMP;
			3'h4: dio_opt_dec = dio_pkg::DIO_OPT_TRIG_GATE;
			default: dio_opt_dec = dio_pkg::DIO_OPT_NONE;
		endcase
	endfunction : dio_opt_dec

	// ----------------------------------------
	// Pulse channels
	// ----------------------------------------
	genvar g;
	generate
		for (g = 0; g < NCH; g++) begin : g_ch
			dio_pulse_ch #(
				.CNT_W(CNT_W)
			) u_ch (
				.i_ref_clk(i_ref_clk),
				.i_rst_n(i_rst_n),
				.i_ce(i_ce),
				.i_trig(r_q.trig[g]),
				.i_width(r_q.width),
				.i_hold(r_q.hold),
				.o_active(ch_active[g]),
				.o_holding(ch_holding[g])
			);
		end
	endgenerate

	// Inputs are synchronous; polarity bit set means active-high.
	always_comb begin
		in_asserted = '0;
		for (int i = 0; i < NCH; i++) begin
			if (r_q.opt == dio_pkg::DIO_OPT_ECHO_LOOP) begin
				in_asserted[i] = r_q.pol[dio_pkg::DIO_POL_LOOP_LO + i] ?
					i_loop_in[i] : !i_loop_in[i];
			end else begin
				in_asserted[i] = r_q.pol[dio_pkg::DIO_POL_GATEIN_LO + i] ?
					i_gate_in[i] : !i_gate_in[i];
			end
		end
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		logic acc;
		logic [31:0] rd;
		acc = i_psel && i_penable;
		rd = '0;
		r_d = r_q;
		r_d.trig = '0;

		// Bus writes. Zero-wait slave: each access completes in its first access cycle while i_ce is high.
		if (acc && i_pwrite && dio_is_mapped(i_paddr)) begin
			case (i_paddr)
				dio_pkg::DIO_A_CTRL: begin
					r_d.test_en = i_pwdata[dio_pkg::DIO_CTRL_EN];
					r_d.opt = dio_opt_dec(i_pwdata[dio_pkg::DIO_CTRL_OPT_LO +: 3]);
				end
				dio_pkg::DIO_A_POL: r_d.pol = i_pwdata[15:0];
				dio_pkg::DIO_A_WIDTH: r_d.width = i_pwdata[CNT_W-1:0];
				dio_pkg::DIO_A_HOLD: r_d.hold = i_pwdata[CNT_W-1:0];
				dio_pkg::DIO_A_TRIG: begin
					// Triggers outside an output option are ignored.
					if (r_q.test_en && (r_q.opt == dio_pkg::DIO_OPT_TRIG_LAMP ||
						r_q.opt == dio_pkg::DIO_OPT_TRIG_GATE)) begin
						r_d.trig = i_pwdata[NCH-1:0];
					end
				end
				default: r_d.trig = '0;
			endcase
		end

		// Bus reads.
		case (i_paddr)
			dio_pkg::DIO_A_CTRL: begin
				rd[dio_pkg::DIO_CTRL_EN] = r_q.test_en;
				rd[dio_pkg::DIO_CTRL_OPT_LO +: 3] = r_q.opt;
			end
			dio_pkg::DIO_A_POL: rd[15:0] = r_q.pol;
			dio_pkg::DIO_A_WIDTH: rd[CNT_W-1:0] = r_q.width;
			dio_pkg::DIO_A_HOLD: rd[CNT_W-1:0] = r_q.hold;
			dio_pkg::DIO_A_STAT: begin
				rd[dio_pkg::DIO_STAT_BUSY_LO +: NCH] = ch_active;
				rd[dio_pkg::DIO_STAT_HOLD_LO +: NCH] = ch_holding;
				rd[dio_pkg::DIO_STAT_LIGHT_LO +: NCH] = r_q.lights;
				rd[dio_pkg::DIO_STAT_TEST_LO] = r_q.test_en;
			end
			default: rd = '0;
		endcase
		if (i_psel && !i_penable) begin
			r_d.prdata = rd;
			r_d.pslverr = !dio_is_mapped(i_paddr);
		end

		// Outputs: inactive level follows polarity; bit set means active-high.
		r_d.normal_en = !r_q.test_en;
		for (int i = 0; i < NCH; i++) begin
			r_d.lamp[i] = !r_q.pol[dio_pkg::DIO_POL_LAMP_LO + i];
			r_d.gate[i] = !r_q.pol[dio_pkg::DIO_POL_GATEOUT_LO + i];
			if (r_q.test_en && ch_active[i]) begin
				if (r_q.opt == dio_pkg::DIO_OPT_TRIG_LAMP) begin
					r_d.lamp[i] = r_q.pol[dio_pkg::DIO_POL_LAMP_LO + i];
				end else if (r_q.opt == dio_pkg::DIO_OPT_TRIG_GATE) begin
					r_d.gate[i] = r_q.pol[dio_pkg::DIO_POL_GATEOUT_LO + i];
				end
			end
		end

		// Lights: normal read indication unless in test.
		if (!r_q.test_en) begin
			r_d.lights = i_read_light;
		end else begin
			case (r_q.opt)
				dio_pkg::DIO_OPT_ECHO_LOOP: r_d.lights = in_asserted;
				dio_pkg::DIO_OPT_ECHO_GATE: r_d.lights = in_asserted;
				dio_pkg::DIO_OPT_TRIG_LAMP: r_d.lights = ch_active;
				dio_pkg::DIO_OPT_TRIG_GATE: r_d.lights = ch_active;
				default: r_d.lights = '0;
			endcase
		end
	end

	// Register everything; the enable freezes all state.
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			r_q.test_en <= 1'b0;
			r_q.opt <= dio_pkg::DIO_OPT_NONE;
			r_q.pol <= dio_pkg::DIO_POL_RST;
			r_q.width <= WIDTH_RST;
			r_q.hold <= HOLD_RST;
			r_q.trig <= '0;
			r_q.prdata <= '0;
			r_q.pslverr <= 1'b0;
			r_q.lamp <= '1;
			r_q.gate <= '1;
			r_q.lights <= '0;
			r_q.normal_en <= 1'b1;
		end else if (i_ce) begin
			r_q <= r_d;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// Ready is held low while frozen so no access completes unseen.
	assign o_pready = i_ce;
	assign o_pslverr = r_q.pslverr && i_psel && i_penable;
	assign o_prdata = r_q.prdata;
	assign o_lamp_out = r_q.lamp;
	assign o_gate_out = r_q.gate;
	assign o_channel_a_light = r_q.lights[0];
	assign o_channel_b_light = r_q.lights[1];
	assign o_channel_c_light = r_q.lights[2];
	assign o_channel_d_light = r_q.lights[3];
	assign o_normal_en = r_q.normal_en;

endmodule : dio_test_top

/* File: pkg/dio_pkg.sv */
// Package with constants, enumerations and carrier structs for the discrete I/O test block.
package dio_pkg;

	// ----------------------------------------
	// Sizes and timing
	// ----------------------------------------
	localparam int unsigned DIO_NCH = 4;
	localparam int unsigned DIO_CLK_MHZ = 100;
	localparam int unsigned DIO_CNT_W = 24;
	localparam int unsigned DIO_PULSE_US_DEF = 100;
	localparam int unsigned DIO_HOLD_US_DEF = 100;
	localparam int unsigned DIO_PULSE_CYC_DEF = DIO_PULSE_US_DEF * DIO_CLK_MHZ;
	localparam int unsigned DIO_HOLD_CYC_DEF = DIO_HOLD_US_DEF * DIO_CLK_MHZ;

	// ----------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------
	localparam logic [11:0] DIO_A_CTRL = 12'h000;
	localparam logic [11:0] DIO_A_POL = 12'h004;
	localparam logic [11:0] DIO_A_WIDTH = 12'h008;
	localparam logic [11:0] DIO_A_HOLD = 12'h00C;
	localparam logic [11:0] DIO_A_TRIG = 12'h010;
	localparam logic [11:0] DIO_A_STAT = 12'h014;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int unsigned DIO_CTRL_EN = 0;
	localparam int unsigned DIO_CTRL_OPT_LO = 1;
	localparam int unsigned DIO_POL_LOOP_LO = 0;
	localparam int unsigned DIO_POL_GATEIN_LO = 4;
	localparam int unsigned DIO_POL_LAMP_LO = 8;
	localparam int unsigned DIO_POL_GATEOUT_LO = 12;
	localparam int unsigned DIO_STAT_BUSY_LO = 0;
	localparam int unsigned DIO_STAT_HOLD_LO = 4;
	localparam int unsigned DIO_STAT_LIGHT_LO = 8;
	localparam int unsigned DIO_STAT_TEST_LO = 12;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [15:0] DIO_POL_RST = 16'h0000;

	// ----------------------------------------
	// Test options
	// ----------------------------------------
	typedef enum logic [2:0] {
		DIO_OPT_NONE = 3'b000,
		DIO_OPT_ECHO_LOOP = 3'b001,
		DIO_OPT_ECHO_GATE = 3'b010,
		DIO_OPT_TRIG_LAMP = 3'b011,
		DIO_OPT_TRIG_GATE = 3'b100
	} dio_opt_t;

	// ----------------------------------------
	// Pulse channel states
	// ----------------------------------------
	typedef enum logic [1:0] {
		DIO_CH_IDLE = 2'b00,
		DIO_CH_PULSE = 2'b01,
		DIO_CH_HOLD = 2'b10
	} dio_ch_state_t;

	// ----------------------------------------
	// Carriers
	// ----------------------------------------
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} dio_apb_req_t;

	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} dio_apb_rsp_t;

	typedef struct packed {
		logic [3:0] loop_in;
		logic [3:0] gate_in;
	} dio_inputs_t;

	typedef struct packed {
		logic [3:0] lamp_out;
		logic [3:0] gate_out;
		logic [3:0] lights;
		logic normal_en;
	} dio_outputs_t;

endpackage : dio_pkg

/* File: core/dio_pulse_ch.sv */
// One output-test pulse channel: pulse for a width, then hold off further triggers.
module dio_pulse_ch #(
	parameter int unsigned CNT_W = dio_pkg::DIO_CNT_W
) (
	// Clock, reset and enable
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	// Control
	input wire logic i_trig,
	input wire logic [CNT_W-1:0] i_width,
	input wire logic [CNT_W-1:0] i_hold,
	// Status
	output logic o_active,
	output logic o_holding
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		dio_pkg::dio_ch_state_t st;
		logic [CNT_W-1:0] cnt;
	} dio_ch_reg_t;

	dio_ch_reg_t r_q;
	dio_ch_reg_t r_d;

	// A zero width or hold still costs one cycle, so a pulse is never lost.
	always_comb begin
		r_d = r_q;
		case (r_q.st)
			dio_pkg::DIO_CH_IDLE: begin
				if (i_trig) begin
					r_d.st = dio_pkg::DIO_CH_PULSE;
					r_d.cnt = i_width;
				end
			end
			dio_pkg::DIO_CH_PULSE: begin
				if (r_q.cnt <= CNT_W'(1)) begin
					r_d.st = dio_pkg::DIO_CH_HOLD;
					r_d.cnt = i_hold;
				end else begin
					r_d.cnt = r_q.cnt - CNT_W'(1);
				end
			end
			dio_pkg::DIO_CH_HOLD: begin
				// Triggers arriving here are dropped on purpose.
				if (r_q.cnt <= CNT_W'(1)) begin
					r_d.st = dio_pkg::DIO_CH_IDLE;
					r_d.cnt = '0;
				end else begin
					r_d.cnt = r_q.cnt - CNT_W'(1);
				end
			end
			default: begin
				r_d.st = dio_pkg::DIO_CH_IDLE;
				r_d.cnt = '0;
			end
		endcase
	end

	// Register the state.
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			r_q <= '{st: dio_pkg::DIO_CH_IDLE, cnt: '0};
		end else if (i_ce) begin
			r_q <= r_d;
		end
	end

	assign o_active = (r_q.st == dio_pkg::DIO_CH_PULSE);
	assign o_holding = (r_q.st == dio_pkg::DIO_CH_HOLD);

endmodule : dio_pulse_ch

/* File: bench/dio_relay_model.sv */
// Relay contacts on the discrete input lines, with the reader's pull-ups.
module dio_relay_model (
	// Contacts
	input wire logic [3:0] i_close,
	// Lines
	output logic [3:0] o_line
);
	timeunit 1ns;
	timeprecision 1ps;
	// A closed contact grounds its line; an open one floats up to the pull-up level.
	assign o_line = ~i_close;
endmodule : dio_relay_model

/* File: bench/dio_test_sva.sv */
// Concurrent checks of the discrete I/O test block, bound to its top module.
module dio_test_sva (
	// Clock, reset and bus
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic o_pready,
	input wire logic o_pslverr,
	// Discrete lines and lights
	input wire logic [3:0] i_loop_in,
	input wire logic [3:0] i_gate_in,
	input wire logic [3:0] i_read_light,
	input wire logic [3:0] o_lamp_out,
	input wire logic [3:0] o_gate_out,
	input wire logic o_channel_a_light,
	input wire logic o_channel_b_light,
	input wire logic o_channel_c_light,
	input wire logic o_channel_d_light,
	input wire logic o_normal_en
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] lt;
	logic wr;
	logic [3:0] ctrl_q;
	logic [15:0] pol_q;
	logic [1:0] calm_q;
	// ----------------------------------------
	// Shadow of mode and polarity
	// ----------------------------------------
	assign lt = {o_channel_d_light, o_channel_c_light, o_channel_b_light, o_channel_a_light};
	assign wr = i_psel && i_penable && i_pwrite && o_pready;
	// The echo and drive checks wait three edges after a mode or polarity change, so the output lag never trips them.
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ctrl_q <= 4'h0;
			pol_q <= 16'h0000;
			calm_q <= 2'h0;
		end else begin
			if (wr && i_paddr == 12'h000) ctrl_q <= i_pwdata[3:0];
			if (wr && i_paddr == 12'h004) pol_q <= i_pwdata[15:0];
			if (wr && i_paddr < 12'h008) calm_q <= 2'h0;
			else if (calm_q != 2'h3) calm_q <= calm_q + 2'h1;
		end
	end
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);
	sequence s_test_on;
		wr && i_paddr == 12'h000 && i_pwdata[0];
	endsequence
	property p_echo(logic [3:0] m, logic [3:0] x, logic [3:0] pl);
		ctrl_q == m && calm_q == 2'h3 |-> lt == ($past(x) ~^ pl);
	endproperty
	property p_drive(logic [3:0] m, logic [3:0] x, logic [3:0] pl);
		ctrl_q == m && calm_q == 2'h3 |-> lt == (x ~^ pl);
	endproperty
	chk_err_access: assert property (o_pslverr |-> i_psel && i_penable)
		else $error("error flag outside access");
	chk_err_unmapped: assert property (i_psel && i_penable && $past(i_psel) &&
		i_paddr > 12'h014 |-> o_pslverr) else $error("unmapped access accepted");
	chk_test_entry: assert property (s_test_on |-> ##[1:2] !o_normal_en)
		else $error("reading not suspended");
	chk_normal_light: assert property (o_normal_en && $past(o_normal_en) && $past(i_rst_n)
		|-> lt == $past(i_read_light)) else $error("read lights wrong");
	chk_loop_echo: assert property (p_echo(4'h3, i_loop_in, pol_q[3:0]))
		else $error("loop echo wrong");
	chk_gate_echo: assert property (p_echo(4'h5, i_gate_in, pol_q[7:4]))
		else $error("gate echo wrong");
	chk_lamp_pulse: assert property (p_drive(4'h7, o_lamp_out, pol_q[11:8]))
		else $error("lamp light mismatch");
	chk_gate_pulse: assert property (p_drive(4'h9, o_gate_out, pol_q[15:12]))
		else $error("gate light mismatch");
endmodule : dio_test_sva

bind dio_test_top dio_test_sva u_sva (.i_ref_clk, .i_rst_n, .i_psel, .i_penable, .i_pwrite,
	.i_paddr, .i_pwdata, .o_pready, .o_pslverr, .i_loop_in, .i_gate_in, .i_read_light,
	.o_lamp_out, .o_gate_out, .o_channel_a_light, .o_channel_b_light, .o_channel_c_light,
	.o_channel_d_light, .o_normal_en);

/* File: bench/discrete_io_test_mode_tb.sv */
// Self-checking testbench of the discrete I/O test block.
`define CHK(nm, e, s) begin n_compared++; if ((s) !== (e)) begin errors++; $display("BAD %s expected %0h seen %0h", nm, e, s); end end

module discrete_io_test_mode_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_ref_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic i_ce = 1'b1;
	logic i_psel = 1'b0;
	logic i_penable = 1'b0;
	logic i_pwrite = 1'b0;
	logic [11:0] i_paddr = 12'h000;
	logic [31:0] i_pwdata = 32'h0;
	logic [3:0] i_read_light = 4'h0;
	logic [3:0] loop_close = 4'h0;
	logic [3:0] gate_close = 4'h0;
	logic [3:0] i_loop_in, i_gate_in, o_lamp_out, o_gate_out, lt;
	logic o_pready, o_pslverr, o_normal_en, er;
	logic o_channel_a_light, o_channel_b_light, o_channel_c_light, o_channel_d_light;
	logic [31:0] o_prdata, rd;
	logic [31:0] rv[6] = '{32'h0, 32'h0, 32'h5, 32'h5, 32'h0, 32'h0};
	int errors = 0;
	int n_compared = 0;
	int cyc = 0;
	// ----------------------------------------
	// Clock, relays and design
	// ----------------------------------------
	assign lt = {o_channel_d_light, o_channel_c_light, o_channel_b_light, o_channel_a_light};
	always #5 i_ref_clk = ~i_ref_clk;
	dio_relay_model u_loop (.i_close(loop_close), .o_line(i_loop_in));
	dio_relay_model u_gate (.i_close(gate_close), .o_line(i_gate_in));
	// Short reset width and hold of 5, checked by the reset read-back; each pulse scenario writes its own.
	dio_test_top #(.WIDTH_RST(24'h000005), .HOLD_RST(24'h000005)) uut (.i_ref_clk, .i_rst_n,
		.i_ce, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_pready, .o_pslverr,
		.o_prdata, .i_loop_in, .i_gate_in, .i_read_light, .o_lamp_out, .o_gate_out,
		.o_channel_a_light, .o_channel_b_light, .o_channel_c_light, .o_channel_d_light,
		.o_normal_en);
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic give_verdict();
		$display("Compared %0d, mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : give_verdict
	// One bus transfer; the idle edge in front avoids driving psel twice in one step.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge i_ref_clk);
		i_psel <= 1'b1;
		i_pwrite <= w;
		i_paddr <= a;
		i_pwdata <= d;
		@(posedge i_ref_clk);
		i_penable <= 1'b1;
		do @(posedge i_ref_clk); while (o_pready !== 1'b1);
		rd = o_prdata;
		er = o_pslverr;
		i_psel <= 1'b0;
		i_penable <= 1'b0;
	endtask : apb
	// Queue model of one pulse; a retrigger lands inside the hold-off and must vanish.
	task automatic pulse_test(input logic [2:0] o);
		logic [3:0] m;
		logic [3:0] p;
		logic [3:0] x;
		int w;
		int h;
		logic [3:0] exp_q[$];
		m = 4'($urandom_range(15, 1));
		p = 4'($urandom);
		w = $urandom_range(3, 1);
		h = $urandom_range(9, 7);
		apb(1'b1, 12'h004, {16'h0, p, p, p, p});
		apb(1'b1, 12'h008, 32'(w));
		apb(1'b1, 12'h00C, 32'(h));
		apb(1'b1, 12'h000, {28'h0, o, 1'b1});
		for (int k = 1; k <= w + h + 4; k++) begin
			exp_q.push_back((k >= 3 && k <= w + 2) ? m : 4'h0);
		end
		apb(1'b1, 12'h010, {28'h0, m});
		fork
			while (exp_q.size() > 0) begin
				@(posedge i_ref_clk);
				x = exp_q.pop_front();
				`CHK("lights", x, lt)
				`CHK("pulse out", p ~^ x, o == 3'h3 ? o_lamp_out : o_gate_out)
				`CHK("idle out", ~p, o == 3'h3 ? o_gate_out : o_lamp_out)
			end
			begin
				repeat (w + 2) @(posedge i_ref_clk);
				apb(1'b1, 12'h010, {28'h0, m});
			end
		join
	endtask : pulse_test
	// A hung handshake ends the run as a mismatch.
	always @(posedge i_ref_clk) begin
		cyc++;
		if (cyc == 5000) begin
			errors++;
			give_verdict();
		end
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		logic [3:0] p;
		rd = 32'($urandom(32'hF3C5));
		repeat (5) @(posedge i_ref_clk);
		i_rst_n <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			apb(1'b0, 12'(4 * i), 32'h0);
			`CHK("reset value", rv[i], rd)
		end
		apb(1'b0, 12'h018, 32'h0);
		`CHK("unmapped error", 1'b1, er)
		`CHK("unmapped data", 32'h0, rd)
		i_read_light <= 4'($urandom);
		repeat (3) @(posedge i_ref_clk);
		`CHK("read lights", i_read_light, lt)
		// Echo options, with a stray trigger that these options must ignore.
		for (int o = 1; o <= 2; o++) begin
			p = 4'($urandom);
			apb(1'b1, 12'h004, {16'h0, p, p, p, p});
			apb(1'b1, 12'h000, {28'h0, 3'(o), 1'b1});
			apb(1'b1, 12'h010, 32'h0000000F);
			repeat (4) begin
				loop_close <= 4'($urandom);
				gate_close <= 4'($urandom);
				repeat (3) @(posedge i_ref_clk);
				`CHK("echo", (o == 1 ? i_loop_in : i_gate_in) ~^ p, lt)
				`CHK("lamp idle", ~p, o_lamp_out)
			end
			`CHK("normal off", 1'b0, o_normal_en)
		end
		pulse_test(3'h3);
		pulse_test(3'h4);
		apb(1'b1, 12'h000, 32'h0);
		repeat (3) @(posedge i_ref_clk);
		`CHK("normal back", 1'b1, o_normal_en)
		give_verdict();
	end
endmodule : discrete_io_test_mode_tb
